// >>> verilog/bcp_port_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module bcp_port_top
   import bcp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire bcp_mode_t op_mode,
   input wire logic port_emulation_bit,
   input wire logic pullup_ctrl,
   input wire logic [BCP_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] pin_in,
   input wire logic queue_status_hi,
   input wire logic queue_status_lo,
   input wire logic pll_test_sig,
   input wire logic bus_timing_clock_out_int,
   input wire logic low_byte_strobe,
   input wire logic read_write,
   output logic [7:0] reg_rdata_q,
   output logic ext_access_q,
   output logic [7:0] pin_out_q,
   output logic [7:0] pin_oe_q,
   output logic [7:0] pullup_en_q,
   output logic auxiliary_reset_in_q,
   output logic irq_level_q,
   output logic nonmaskable_interrupt_in_q,
   output logic bus_timing_clock_out_from_pin_q
);

   logic [7:0] data_q; // Port data register, no reset
   logic [7:0] dir_q; // Direction register
   logic [7:0] dir_d;
   logic [7:0] asg_q; // Assignment register
   logic [7:0] asg_d;
   logic asg_seen_q; // A write to the assignment register happened
   logic [7:0] data_fresh_q; // Pins that keep their reset drive until software writes data
   bcp_pin_if pif ();

   // Mode classes
   wire is_single = bcp_single(op_mode);
   wire is_special = bcp_special(op_mode);
   wire is_periph = (op_mode == BCP_PER);
   wire is_nen = (op_mode == BCP_NEN);
   wire is_nexp = (op_mode == BCP_NEN) || (op_mode == BCP_NEW);

   // Address decode; data and direction vanish when the port is emulated
   wire port_mapped = !is_periph && !(bcp_expanded(op_mode) && port_emulation_bit);
   wire hit_data = (reg_addr == BCP_OFF_DATA);
   wire hit_dir = (reg_addr == BCP_OFF_DIR);
   wire hit_asg = (reg_addr == BCP_OFF_ASG) && !is_periph;
   wire hit_port = (hit_data || hit_dir) && port_mapped;
   wire divert = (hit_data || hit_dir) && !port_mapped && !is_periph;
   wire wr_data = reg_wr && hit_data && port_mapped;
   wire wr_dir = reg_wr && hit_dir && port_mapped;
   wire wr_asg = reg_wr && hit_asg;

   // Write permission per assignment field
   wire once_ok = is_special ? asg_seen_q : !asg_seen_q;
   wire pll_ok = is_special && asg_seen_q;
   wire no_external_eclock_ok = !is_special;
   logic [7:0] asg_wen;
   assign asg_wen[BCP_B_AUXILIARY_RESET_IN] = 1'b1;
   assign asg_wen[BCP_B_PLL] = pll_ok;
   assign asg_wen[BCP_B_PIPE] = once_ok;
   assign asg_wen[BCP_B_NO_EXTERNAL_ECLOCK] = no_external_eclock_ok;
   assign asg_wen[BCP_B_LSTR] = once_ok;
   assign asg_wen[BCP_B_RDW] = once_ok;
   assign asg_wen[1:0] = 2'b00;

   // Mode-dependent reset value of the assignment register
   logic [7:0] asg_rst;
   always_comb
   begin
      unique case (op_mode)
         BCP_NSC: asg_rst = BCP_ASG_RST_NSC;
         BCP_NEN, BCP_NEW: asg_rst = BCP_ASG_RST_NEX;
         BCP_PER: asg_rst = BCP_ASG_RST_PER;
         BCP_SSC, BCP_SEN, BCP_SEW: asg_rst = BCP_ASG_RST_SPC;
         default: asg_rst = BCP_ASG_RST_NSC;
      endcase
   end

   // Pin three must come out of reset driving high in narrow normal expanded
   wire [7:0] dir_rst = is_nen ? BCP_DIR_RST_NEN : BCP_DIR_RST;
   wire [7:0] out_rst = is_nen ? BCP_DIR_RST_NEN : BCP_ZERO8;
   // Reset leaves the data latch alone, so the reset drive level is laid
   // over it until the first data write; pin three stays high until that write
   wire [7:0] data_eff = data_q | data_fresh_q;

   // Next values of direction and assignment
   assign dir_d = wr_dir ? (reg_wdata & BCP_DIR_MASK) : dir_q;
   assign asg_d = wr_asg ? ((reg_wdata & asg_wen) | (asg_q & ~asg_wen)) & BCP_ASG_MASK
                         : asg_q;

   // Effective alternate functions; mode gates most of them
   wire auxiliary_reset_in_on = asg_q[BCP_B_AUXILIARY_RESET_IN];
   wire pipe_on = asg_q[BCP_B_PIPE] && !is_single;
   wire pll_on = asg_q[BCP_B_PLL] && !is_single && !is_nexp;
   wire bus_timing_clock_out_on = !asg_q[BCP_B_NO_EXTERNAL_ECLOCK];
   wire low_byte_strobe_on = asg_q[BCP_B_LSTR] && !is_single && !is_nen;
   wire rdw_on = asg_q[BCP_B_RDW] && !is_single;

   // Alternate selection table handed to the pin cells
   assign pif.alt_sel = {auxiliary_reset_in_on, pipe_on || pll_on, pipe_on, bus_timing_clock_out_on,
                         low_byte_strobe_on, rdw_on, 2'b00};
   assign pif.alt_oe = {1'b0, 1'b1, 1'b1, !is_periph, 1'b1, 1'b1, 2'b00};
   assign pif.alt_val = {1'b0, pipe_on ? queue_status_hi : pll_test_sig,
                         queue_status_lo, bus_timing_clock_out_int, low_byte_strobe, read_write, 2'b00};
   assign pif.dir = dir_q;
   assign pif.dat = data_eff;

   bcp_pin_mux u_mux (
      .pif (pif.mux)
   );

   // Port reads: driven pins show the latch, inputs show the pin level
   wire [7:0] port_view = (data_eff & pif.pin_oe) | (pin_in & ~pif.pin_oe);
   wire [7:0] rd_mux = !reg_rd ? BCP_ZERO8 :
                       (hit_data && port_mapped) ? port_view :
                       (hit_dir && port_mapped) ? dir_q :
                       hit_asg ? (asg_q & BCP_ASG_MASK) : BCP_ZERO8;

   // Pullups only on undriven pins; the IRQ pin keeps its own
   wire [7:0] pu_d = {4'h0,
                      pullup_ctrl && !pif.pin_oe[BCP_P_LOW_BYTE_STROBE],
                      pullup_ctrl && !pif.pin_oe[BCP_P_RDW],
                      1'b1,
                      pullup_ctrl};

   // Data register keeps its contents across reset
   always_ff @(posedge sys_clk)
   begin
      if (wr_data)
      begin
         data_q <= reg_wdata;
      end
   end

   // Control registers with mode-dependent reset
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         dir_q <= dir_rst;
         asg_q <= asg_rst;
         asg_seen_q <= 1'b0;
         data_fresh_q <= out_rst;
      end
      else
      begin
         dir_q <= dir_d;
         asg_q <= asg_d;
         asg_seen_q <= asg_seen_q || wr_asg;
         data_fresh_q <= wr_data ? BCP_ZERO8 : data_fresh_q;
      end
   end

   // Bus answer, one cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         reg_rdata_q <= BCP_ZERO8;
         ext_access_q <= 1'b0;
      end
      else
      begin
         reg_rdata_q <= rd_mux;
         ext_access_q <= (reg_rd || reg_wr) && divert;
      end
   end

   // Pin drive registered so outputs come straight from flops
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         pin_out_q <= out_rst;
         pin_oe_q <= dir_rst;
      end
      else
      begin
         pin_out_q <= pif.pin_out;
         pin_oe_q <= pif.pin_oe;
      end
   end

   // Input-side functions: reset request, interrupt levels, E-clock in
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         pullup_en_q <= pu_d;
         auxiliary_reset_in_q <= 1'b0;
         irq_level_q <= 1'b1;
         nonmaskable_interrupt_in_q <= 1'b1;
         bus_timing_clock_out_from_pin_q <= 1'b0;
      end
      else
      begin
         pullup_en_q <= pu_d;
         // High-true reset request, same path as the main reset pin
         auxiliary_reset_in_q <= auxiliary_reset_in_on && pin_in[BCP_P_AUXILIARY_RESET_IN];
         // Interrupt levels pass whether or not the interrupts are on
         irq_level_q <= pin_in[BCP_P_IRQ];
         nonmaskable_interrupt_in_q <= pin_in[BCP_P_NONMASKABLE_INTERRUPT_IN];
         // E-clock taken from the pin only in peripheral mode with the no-E-clock bit clear, which that mode never has
         bus_timing_clock_out_from_pin_q <= is_periph && bus_timing_clock_out_on && pin_in[BCP_P_BUS_TIMING_CLOCK_OUT];
      end
   end

   // Checks on the design's own behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence asg_write_s;
      reg_wr && (reg_addr == BCP_OFF_ASG);
   endsequence

   irq_never_out_a: assert property (pin_oe_q[1:0] == 2'b00)
      else $error("interrupt pin driven");

   bus_timing_clock_out_dir_a: assert property (bus_timing_clock_out_on && !is_periph |=> pin_oe_q[BCP_P_BUS_TIMING_CLOCK_OUT])
      else $error("bus_timing_clock_out pin not output");

   pipe_drive_a: assert property (pipe_on |=> pin_oe_q[BCP_P_QLO]
      && pin_out_q[BCP_P_QLO] == $past(queue_status_lo))
      else $error("queue status not on pin five");

   pll_normal_a: assert property (asg_write_s and !is_special |=>
      asg_q[BCP_B_PLL] == $past(asg_q[BCP_B_PLL]))
      else $error("pll bit written in normal mode");

   first_skip_a: assert property (asg_write_s and is_special && !is_periph
      && !asg_seen_q |=> asg_q[5:2] == $past(asg_q[5:2]) && asg_seen_q)
      else $error("first special write took effect");

   no_external_eclock_special_a: assert property (asg_write_s and is_special |=>
      asg_q[BCP_B_NO_EXTERNAL_ECLOCK] == $past(asg_q[BCP_B_NO_EXTERNAL_ECLOCK]))
      else $error("no-bus_timing_clock_out bit written in special mode");

   asg_low_zero_a: assert property (reg_rd && hit_asg |=>
      reg_rdata_q[1:0] == 2'b00 && reg_rdata_q[7:2] == $past(asg_q[7:2]))
      else $error("assignment read wrong");

   emu_divert_a: assert property ((reg_rd || reg_wr) && divert
      |=> ext_access_q ##1 !ext_access_q || $past(reg_rd || reg_wr))
      else $error("emulated access not diverted");

   hidden_read_a: assert property (reg_rd && hit_data && !port_mapped
      |=> reg_rdata_q == BCP_ZERO8)
      else $error("hidden data register answered");

   aux_reset_a: assert property (auxiliary_reset_in_on && pin_in[BCP_P_AUXILIARY_RESET_IN]
      |=> auxiliary_reset_in_q)
      else $error("aux reset not passed");

   nen_reset_a: assert property (disable iff (1'b0) !nrst && is_nen
      |=> pin_oe_q[BCP_P_LOW_BYTE_STROBE] && pin_out_q[BCP_P_LOW_BYTE_STROBE])
      else $error("pin three not high in reset");

   nen_release_a: assert property ($rose(nrst) && is_nen
      |=> pin_oe_q[BCP_P_LOW_BYTE_STROBE] && pin_out_q[BCP_P_LOW_BYTE_STROBE])
      else $error("pin three not high after reset");

   // Pin cell checks: alternate drive against direction bits, then pullup, assignment-write and register-access checks

   gp_dir_a: assert property (!auxiliary_reset_in_on |=>
      pin_oe_q[BCP_P_AUXILIARY_RESET_IN] == $past(dir_q[BCP_P_AUXILIARY_RESET_IN]))
      else $error("pin seven ignores direction bit");

   alt_over_dir_a: assert property (auxiliary_reset_in_on && dir_q[BCP_P_AUXILIARY_RESET_IN] |=>
      !pin_oe_q[BCP_P_AUXILIARY_RESET_IN])
      else $error("direction bit beat alternate function");

   pullup_mask_a: assert property (pullup_en_q[BCP_P_IRQ]
      && pullup_en_q[7:4] == 4'h0)
      else $error("pullup set wrong");

   auxiliary_reset_in_write_a: assert property (asg_write_s and !is_periph |=>
      asg_q[BCP_B_AUXILIARY_RESET_IN] == $past(reg_wdata[BCP_B_AUXILIARY_RESET_IN]))
      else $error("aux reset enable not written");

   pll_pin_a: assert property (pll_on && !pipe_on |=> pin_oe_q[BCP_P_QHI]
      && pin_out_q[BCP_P_QHI] == $past(pll_test_sig))
      else $error("pll test not on pin six");

   once_normal_a: assert property (asg_write_s and !is_special && asg_seen_q |=>
      asg_q[BCP_B_PIPE] == $past(asg_q[BCP_B_PIPE])
      && asg_q[BCP_B_LSTR:BCP_B_RDW] == $past(asg_q[BCP_B_LSTR:BCP_B_RDW]))
      else $error("second normal write took effect");

   low_byte_strobe_gate_a: assert property ((is_single || is_nen) && !dir_q[BCP_P_LOW_BYTE_STROBE] |=>
      !pin_oe_q[BCP_P_LOW_BYTE_STROBE])
      else $error("low strobe driven where it has no effect");

   rdw_pin_a: assert property (rdw_on |=> pin_oe_q[BCP_P_RDW]
      && pin_out_q[BCP_P_RDW] == $past(read_write))
      else $error("read/write not on pin two");

   hidden_write_a: assert property (reg_wr && hit_dir && !port_mapped |=>
      dir_q == $past(dir_q))
      else $error("hidden direction register written");

   periph_quiet_a: assert property (reg_rd && is_periph |=>
      reg_rdata_q == BCP_ZERO8)
      else $error("register answered in peripheral mode");

   // Reset images for normal single-chip and special expanded, seen at the first edge after release

   nsc_image_a: assert property ($rose(nrst) && op_mode == BCP_NSC |->
      asg_q == BCP_ASG_RST_NSC)
      else $error("normal single-chip reset image wrong");

   spx_image_a: assert property ($rose(nrst) && is_special && bcp_expanded(op_mode) |->
      asg_q == BCP_ASG_RST_SPC)
      else $error("special expanded reset image wrong");

endmodule

// >>> include/bcp_pkg.sv
package bcp_pkg;

   // Operating modes of the chip, fed in by the mode logic
   typedef enum logic [2:0] {
      BCP_NSC,   // Normal single-chip
      BCP_NEN,   // Normal expanded narrow
      BCP_NEW,   // Normal expanded wide
      BCP_SSC,   // Special single-chip
      BCP_SEN,   // Special expanded narrow
      BCP_SEW,   // Special expanded wide
      BCP_PER    // Peripheral
   } bcp_mode_t;

   // Register word offsets on the local port
   localparam int BCP_AW = 8;
   localparam logic [7:0] BCP_OFF_DATA = 8'h08;
   localparam logic [7:0] BCP_OFF_DIR = 8'h09;
   localparam logic [7:0] BCP_OFF_ASG = 8'h0a;

   // Assignment register field positions
   localparam int BCP_B_AUXILIARY_RESET_IN = 7;
   localparam int BCP_B_PLL = 6;
   localparam int BCP_B_PIPE = 5;
   localparam int BCP_B_NO_EXTERNAL_ECLOCK = 4;
   localparam int BCP_B_LSTR = 3;
   localparam int BCP_B_RDW = 2;

   // Pin numbers of the alternate functions
   localparam int BCP_P_AUXILIARY_RESET_IN = 7;
   localparam int BCP_P_QHI = 6;
   localparam int BCP_P_QLO = 5;
   localparam int BCP_P_BUS_TIMING_CLOCK_OUT = 4;
   localparam int BCP_P_LOW_BYTE_STROBE = 3;
   localparam int BCP_P_RDW = 2;
   localparam int BCP_P_IRQ = 1;
   localparam int BCP_P_NONMASKABLE_INTERRUPT_IN = 0;

   // Implemented bits of assignment and direction registers
   localparam logic [7:0] BCP_ASG_MASK = 8'hfc;
   localparam logic [7:0] BCP_DIR_MASK = 8'hfc;

   // Reset values of the assignment register per mode
   localparam logic [7:0] BCP_ASG_RST_SPC = 8'h2c;
   localparam logic [7:0] BCP_ASG_RST_PER = 8'h50;
   localparam logic [7:0] BCP_ASG_RST_NSC = 8'h10;
   localparam logic [7:0] BCP_ASG_RST_NEX = 8'h00;

   // Reset values of direction and pin drive
   localparam logic [7:0] BCP_DIR_RST_NEN = 8'h08;
   localparam logic [7:0] BCP_DIR_RST = 8'h00;
   localparam logic [7:0] BCP_ZERO8 = 8'h00;

   // Mode classes used all over the block
   function automatic logic bcp_single(input bcp_mode_t m);
      return (m == BCP_NSC) || (m == BCP_SSC);
   endfunction

   function automatic logic bcp_special(input bcp_mode_t m);
      return (m == BCP_SSC) || (m == BCP_SEN) || (m == BCP_SEW) || (m == BCP_PER);
   endfunction

   function automatic logic bcp_expanded(input bcp_mode_t m);
      return (m == BCP_NEN) || (m == BCP_NEW) || (m == BCP_SEN) || (m == BCP_SEW);
   endfunction

endpackage

// >>> include/bcp_pin_if.sv
`timescale 1ns/1ps
// Per-pin selection between general-purpose and alternate drive
interface bcp_pin_if;
   logic [7:0] alt_sel; // Pin carries its alternate function
   logic [7:0] alt_oe; // Alternate function drives the pin
   logic [7:0] alt_val; // Alternate output value
   logic [7:0] dir; // Direction register
   logic [7:0] dat; // Data register
   logic [7:0] pin_out; // Resolved output value
   logic [7:0] pin_oe; // Resolved output enable
   modport ctrl (output alt_sel, output alt_oe, output alt_val, output dir, output dat,
                 input pin_out, input pin_oe);
   modport mux (input alt_sel, input alt_oe, input alt_val, input dir, input dat,
                output pin_out, output pin_oe);
endinterface

// >>> verilog/bcp_pin_mux.sv
`timescale 1ns/1ps
module bcp_pin_mux
   import bcp_pkg::*;
(
   bcp_pin_if.mux pif
);

   // One cell per pin; alternate function outranks direction bit
   for (genvar i = 0; i < 8; i++)
   begin : g_pin
      // Interrupt pins are never driven, whatever software writes
      localparam logic can_drive = (i != BCP_P_IRQ) && (i != BCP_P_NONMASKABLE_INTERRUPT_IN);
      wire gp_oe = pif.dir[i] && can_drive;
      assign pif.pin_oe[i] = pif.alt_sel[i] ? (pif.alt_oe[i] && can_drive) : gp_oe;
      assign pif.pin_out[i] = pif.alt_sel[i] ? pif.alt_val[i] : pif.dat[i];
   end

endmodule

// >>> verif/bcp_far_model.sv
`timescale 1ns/1ps
// Board side of the port: outside drivers, pullups and floating lines
module bcp_far_model
   import bcp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [7:0] pin_out_q,
   input wire logic [7:0] pin_oe_q,
   input wire logic [7:0] pullup_en_q,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_in
);
   logic [7:0] float_q = 8'h55; // Level of an undriven, unpulled line
   wire [7:0] free_w = ~pin_oe_q & ~ext_en; // Nobody drives these pins

   // A floating line flips every cycle so no stale level can pass a check
   always @(posedge sys_clk)
   begin
      float_q <= ~float_q;
   end

   // Device drive wins, then the outside driver, then the pullup
   assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_en & ext_val)
                   | (free_w & pullup_en_q) | (free_w & ~pullup_en_q & float_q);
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench
   import bcp_pkg::*;
;
   logic sys_clk = 1'b0; // 10 MHz bus clock
   logic nrst = 1'b0; // Sync reset, active low
   bcp_mode_t op_mode = BCP_NSC; // Chip mode, changed only in reset
   logic peb = 1'b0; // Port emulation bit
   logic pullup_ctrl = 1'b1; // Port pullup enable
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [5:0] alt = 6'h1a; // Sources: queue hi, queue lo, pll, bus_timing_clock_out, strobe, r/w
   logic [7:0] ext_en = 8'h00; // Pins driven from outside
   logic [7:0] ext_val = 8'h00;
   logic [7:0] pin_in;
   logic [7:0] reg_rdata_q;
   logic ext_access_q;
   logic [7:0] pin_out_q;
   logic [7:0] pin_oe_q;
   logic [7:0] pullup_en_q;
   logic aux_q;
   logic irq_q;
   logic nmi_q;
   logic bus_timing_clock_out_q; // E-clock level taken from the pin
   logic [7:0] rd_data; // Last read result
   logic rd_ext; // External-access flag of last read
   int fails = 0;
   int checked = 0;
   int cycles = 0;

   bcp_port_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .op_mode(op_mode),
      .port_emulation_bit(peb), .pullup_ctrl(pullup_ctrl), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .pin_in(pin_in),
      .queue_status_hi(alt[5]), .queue_status_lo(alt[4]), .pll_test_sig(alt[3]),
      .bus_timing_clock_out_int(alt[2]), .low_byte_strobe(alt[1]), .read_write(alt[0]),
      .reg_rdata_q(reg_rdata_q), .ext_access_q(ext_access_q), .pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q), .pullup_en_q(pullup_en_q), .auxiliary_reset_in_q(aux_q),
      .irq_level_q(irq_q), .nonmaskable_interrupt_in_q(nmi_q), .bus_timing_clock_out_from_pin_q(bus_timing_clock_out_q));

   bcp_far_model far_u (.sys_clk(sys_clk), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
      .pullup_en_q(pullup_en_q), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // Clock and hang guard; the whole run needs well under 2000 cycles
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         fails = fails + 1;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked = checked + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Reset in a mode; NEN pin three must already drive high during reset
   task automatic rst(input bcp_mode_t m);
      @(posedge sys_clk);
      op_mode <= m;
      nrst <= 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      if (m == BCP_NEN)
         chk("oe in reset", pin_oe_q & pin_out_q, 8'h08);
      @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data and flag stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_data = reg_rdata_q;
      rd_ext = ext_access_q;
   endtask

   // Pins trail the registers by one cycle
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_reset();
      bcp_mode_t md [7] = '{BCP_NSC, BCP_NEN, BCP_NEW, BCP_SSC, BCP_SEN, BCP_SEW, BCP_PER};
      logic [7:0] ea [7] = '{8'h10, 8'h00, 8'h00, 8'h2c, 8'h2c, 8'h2c, 8'h00};
      logic [7:0] eo [7] = '{8'h00, 8'h18, 8'h10, 8'h10, 8'h7c, 8'h7c, 8'h40};
      ext_en <= 8'h10;
      ext_val <= 8'h10;
      for (int i = 0; i < 7; i++)
      begin
         rst(md[i]);
         rd(BCP_OFF_ASG);
         chk("asg reset", rd_data, ea[i]);
         rd(BCP_OFF_DIR);
         chk("dir reset", rd_data, (md[i] == BCP_NEN) ? 8'h08 : 8'h00);
         chk("oe reset", pin_oe_q, eo[i]);
         if (md[i] == BCP_NEN)
            chk("nen out", pin_out_q & 8'h08, 8'h08);
      end
      chk("pll pin", pin_out_q & 8'h40, 8'h40);
      chk("bus_timing_clock_out in", {7'h00, bus_timing_clock_out_q}, 8'h00);
      $display("t_reset done");
   endtask

   task automatic t_gpio();
      rst(BCP_NSC);
      ext_en <= 8'hf3;
      ext_val <= 8'h90;
      wr(BCP_OFF_DIR, 8'hff);
      wr(BCP_OFF_DATA, 8'ha5);
      settle();
      chk("gpio oe", pin_oe_q, 8'hfc);
      chk("gpio out", pin_out_q & 8'hfc, 8'ha4);
      chk("irq levels", {6'h00, irq_q, nmi_q}, 8'h00);
      rd(BCP_OFF_DIR);
      chk("dir read", rd_data, 8'hfc);
      wr(BCP_OFF_DIR, 8'h0c);
      settle();
      chk("pullups", pullup_en_q, 8'h03);
      @(posedge sys_clk);
      pullup_ctrl <= 1'b0;
      settle();
      chk("pullups off", pullup_en_q, 8'h02);
      @(posedge sys_clk);
      pullup_ctrl <= 1'b1;
      rd(BCP_OFF_DATA);
      chk("data read", rd_data, 8'h94);
      rst(BCP_NSC);
      wr(BCP_OFF_DIR, 8'h0c);
      settle();
      rd(BCP_OFF_DATA);
      chk("data kept", rd_data, 8'h94);
      wr(BCP_OFF_ASG, 8'h00);
      settle();
      chk("bus_timing_clock_out free", pin_oe_q & 8'h10, 8'h10);
      ext_en <= 8'h80;
      ext_val <= 8'h80;
      $display("t_gpio done");
   endtask

   // Normal expanded: strobes enabled once, before any external write
   task automatic t_normal();
      rst(BCP_NEW);
      wr(BCP_OFF_DIR, 8'h80);
      wr(BCP_OFF_ASG, 8'hff);
      rd(BCP_OFF_ASG);
      chk("asg first", rd_data, 8'hbc);
      chk("aux on", {7'h00, aux_q}, 8'h01);
      chk("auxiliary_reset_in over dir", pin_oe_q & 8'h80, 8'h00);
      wr(BCP_OFF_ASG, 8'h00);
      rd(BCP_OFF_ASG);
      chk("asg second", rd_data, 8'h2c);
      settle();
      chk("alt oe", pin_oe_q, 8'hfc);
      chk("alt out", pin_out_q & 8'h7c, 8'h28);
      chk("irq pulled", {6'h00, irq_q, nmi_q}, 8'h03);
      chk("aux off", {7'h00, aux_q}, 8'h00);
      $display("t_normal done");
   endtask

   task automatic t_special();
      rst(BCP_SEW);
      chk("spc oe", pin_oe_q, 8'h7c);
      chk("spc out", pin_out_q & 8'h7c, 8'h28);
      wr(BCP_OFF_ASG, 8'hff);
      rd(BCP_OFF_ASG);
      chk("spc first", rd_data, 8'hac);
      wr(BCP_OFF_ASG, 8'h40);
      rd(BCP_OFF_ASG);
      chk("spc second", rd_data, 8'h40);
      settle();
      chk("pll oe", pin_oe_q, 8'h50);
      chk("pll out", pin_out_q & 8'h50, 8'h40);
      wr(BCP_OFF_ASG, 8'h60);
      settle();
      chk("pipe oe", pin_oe_q, 8'h70);
      chk("pipe out", pin_out_q & 8'h70, 8'h20);
      $display("t_special done");
   endtask

   task automatic t_emul();
      rst(BCP_NEW);
      peb <= 1'b1;
      rd(BCP_OFF_DATA);
      chk("emu data", rd_data, 8'h00);
      chk("emu ext", {7'h00, rd_ext}, 8'h01);
      wr(BCP_OFF_DIR, 8'hff);
      rd(BCP_OFF_DIR);
      chk("emu dir", rd_data, 8'h00);
      chk("emu ext dir", {7'h00, rd_ext}, 8'h01);
      settle();
      chk("emu oe", pin_oe_q, 8'h10);
      rd(8'h0b);
      chk("unmapped", {rd_data[7:1], rd_ext}, 8'h00);
      peb <= 1'b0;
      $display("t_emul done");
   endtask

   task automatic give_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      t_reset();
      t_gpio();
      t_normal();
      t_special();
      t_emul();
      give_verdict();
   end
endmodule
